// *** shared/acdt_pkg.sv ***
// shared constants and types of the converter output timing block
`default_nettype none
package acdt_pkg;
  // ==========================================================
  // data widths and pipeline depths in input clock cycles
  localparam int unsigned SMP_W    = 8;   // one converted sample
  localparam int unsigned PIPE_PRI = 13;  // latency, primary bus
  localparam int unsigned PIPE_DLY = 14;  // latency, delayed bus
  localparam int unsigned PAIR_W   = 2 * SMP_W + 1; // two buses + flag
  localparam int unsigned BUF_DEPTH = 2;  // entries of output buffer
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ  = 100; // core clock rate
  localparam int unsigned WAKE_NS  = 500; // wake-up to rated accuracy
  // least time, so round up to whole cycles
  localparam int unsigned WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_W   = 8;
  localparam logic [31:0] CAL_DLY_LO_CYC = 32'h0200_0000; // 2^25
  localparam logic [31:0] CAL_DLY_HI_CYC = 32'h8000_0000; // 2^31
  localparam int unsigned DRST_MIN_CYC = 4; // output clock reset width
  // ==========================================================
  // positions in the pin synchroniser vector
  localparam int unsigned SY_SCLK = 0;
  localparam int unsigned SY_PD   = 1;
  localparam int unsigned SY_CAL  = 2;
  localparam int unsigned SY_DRST = 3;
  localparam int unsigned SY_DAT  = 4;
  localparam int unsigned SYNC_W  = SY_DAT + SMP_W;
  // ==========================================================
  // types
  typedef logic [SMP_W-1:0]  acdt_sample_t;
  typedef logic [PAIR_W-1:0] acdt_pair_t;
  typedef enum logic [1:0] {ACDT_OFF, ACDT_WAKE, ACDT_RUN} acdt_pwr_e;
endpackage
`default_nettype wire

// *** shared/acdt_if.sv ***
// stream handshake between the timing core and its output buffer
`default_nettype none
interface acdt_if;
  import acdt_pkg::*;
  logic       in_valid;   // pair offered by the core
  logic       in_ready;   // buffer can take a pair
  acdt_pair_t in_data;    // pair being offered
  logic       out_valid;  // buffer holds a pair
  logic       out_ready;  // receiver takes it
  acdt_pair_t out_data;   // oldest stored pair
  modport buf_side (input in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
  modport core_side (output in_valid, in_data, out_ready,
                     input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** logic/acdt_buf.sv ***
// two-entry output buffer with valid and ready on both sides
`default_nettype none
module acdt_buf
  import acdt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  acdt_if.buf_side  bus
);
  // ==========================================================
  // storage and pointers
  acdt_pair_t           mem_r [BUF_DEPTH];  // flip-flop entries
  acdt_pair_t           mem_nxt [BUF_DEPTH];
  logic                 wr_ptr_r, wr_ptr_nxt;  // next slot to fill
  logic                 rd_ptr_r, rd_ptr_nxt;  // oldest slot
  logic [1:0]           cnt_r, cnt_nxt;        // entries held
  logic                 push, pop;

  // handshakes are combinational, data comes from the entry flops
  assign bus.in_ready  = (cnt_r != 2'h2);
  assign bus.out_valid = (cnt_r != 2'h0);
  assign bus.out_data  = mem_r[rd_ptr_r];

  // ==========================================================
  // next state
  always_comb begin
    push = bus.in_valid && bus.in_ready && ce;
    pop  = bus.out_valid && bus.out_ready && ce;
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt    = cnt_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = bus.in_data;
      wr_ptr_nxt = ~wr_ptr_r;
    end
    if (pop) begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    // simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r    <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// *** logic/acdt_top.sv ***
// converter output demux, wake-up and calibration delay timing core
// ==========================================================
`default_nettype none
module acdt_top
  import acdt_pkg::*;
#(
  parameter logic [31:0] CAL_DLY_LO = CAL_DLY_LO_CYC, // pin low count
  parameter logic [31:0] CAL_DLY_HI = CAL_DLY_HI_CYC  // pin high count
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         sample_clk,
  input  wire acdt_sample_t sample_in,
  input  wire logic         power_down_pin,
  input  wire logic         calibration_delay_select,
  input  wire logic         output_data_clock_reset,
  input  wire logic         out_ready,
  output logic              out_valid,
  output acdt_sample_t      primary_output_bus,
  output acdt_sample_t      delayed_output_bus,
  output logic              out_accurate,
  output logic              output_data_clock,
  output logic              pair_ready,
  output logic              overrun,
  output logic              data_accurate,
  output logic              cal_pending,
  output logic              cal_start
);
  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0]        rst_ff;       // reset release pair
  logic              rst_n;        // released reset for the design
  logic [SYNC_W-1:0] sy1_r;        // first stage, read by sy2_r only
  logic [SYNC_W-1:0] sy2_r;        // second stage, safe to use
  logic              sclk_d_r;     // previous sampled link clock

  assign rst_n = rst_ff[1];

  // assert at once, release two clock edges later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end

  // every pin in the synchroniser vector crosses two flops before any logic looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else if (ce) begin
      sy1_r <= {sample_in, output_data_clock_reset, calibration_delay_select,
                power_down_pin, sample_clk};
      sy2_r <= sy1_r;
    end
  end

  // ==========================================================
  // state of the core
  acdt_sample_t pipe_r [PIPE_DLY];  // conversion pipeline
  acdt_sample_t pipe_nxt [PIPE_DLY];
  logic         phase_r, phase_nxt;       // demux phase
  logic         output_data_clock_r, output_data_clock_nxt;         // output data clock
  logic         ovr_r, ovr_nxt;           // sticky lost pair
  acdt_pwr_e    pwr_r, pwr_nxt;           // power state
  logic [WAKE_W-1:0] wake_r, wake_nxt;    // wake-up timer
  logic [1:0]   cal_lat_r, cal_lat_nxt;   // cycles since release, to 3
  logic         cal_sel_r, cal_sel_nxt;   // captured select level
  logic         cal_pend_r, cal_pend_nxt; // delay still running
  logic         cal_go_r, cal_go_nxt;     // one-cycle start pulse
  logic [31:0]  cal_cnt_r, cal_cnt_nxt;   // input clock cycles seen
  logic [31:0]  cal_tgt;                  // count for chosen pin level
  logic         sedge;                    // rising edge of link clock
  logic         pd;                       // power down, synchronised
  logic         drst;                     // output clock reset held
  acdt_pair_t   pair;                     // pair offered to buffer
  logic         offer;                    // pair offered this cycle

  acdt_if obuf ();

  acdt_buf u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .bus   (obuf.buf_side)
  );

  assign obuf.in_valid  = offer;
  assign obuf.in_data   = pair;
  assign obuf.out_ready = out_ready;
  assign out_valid      = obuf.out_valid;
  assign pair_ready     = obuf.in_ready;

  // buffered data leaves from the buffer's entry flops
  assign primary_output_bus = obuf.out_data[SMP_W-1:0];
  assign delayed_output_bus = obuf.out_data[2*SMP_W-1:SMP_W];
  assign out_accurate       = obuf.out_data[PAIR_W-1];
  assign output_data_clock  = output_data_clock_r;
  assign overrun            = ovr_r;
  assign data_accurate      = (pwr_r == ACDT_RUN);
  assign cal_pending        = cal_pend_r;
  assign cal_start          = cal_go_r;

  // ==========================================================
  // next values of the core
  always_comb begin
    sedge = sy2_r[SY_SCLK] && !sclk_d_r && ce;
    pd    = sy2_r[SY_PD];
    drst  = sy2_r[SY_DRST];
    pipe_nxt     = pipe_r;
    phase_nxt    = phase_r;
    output_data_clock_nxt     = output_data_clock_r;
    ovr_nxt      = ovr_r;
    pwr_nxt      = pwr_r;
    wake_nxt     = wake_r;
    // settle count climbs to 3 and then stays there
    cal_lat_nxt  = (cal_lat_r == 2'h3) ? cal_lat_r : cal_lat_r + 2'h1;
    cal_sel_nxt  = cal_sel_r;
    cal_pend_nxt = cal_pend_r;
    cal_go_nxt   = 1'b0;
    cal_cnt_nxt  = cal_cnt_r;
    cal_tgt      = cal_sel_r ? CAL_DLY_HI : CAL_DLY_LO;
    offer        = 1'b0;
    // the sample converted k edges ago sits in entry k-1
    pair = {(pwr_r == ACDT_RUN), pipe_r[PIPE_DLY-1],
            pipe_r[PIPE_PRI-1]};

    // power state: wake timer restarts on every power-down
    unique case (pwr_r)
      ACDT_OFF: begin
        wake_nxt = '0;
        if (!pd) begin
          pwr_nxt = ACDT_WAKE;
        end
      end
      ACDT_WAKE: begin
        // output flows meanwhile but is marked not accurate
        if (pd) begin
          pwr_nxt = ACDT_OFF;
        end else if (wake_r == WAKE_W'(WAKE_CYC - 1)) begin
          pwr_nxt = ACDT_RUN;
        end else begin
          wake_nxt = wake_r + WAKE_W'(1);
        end
      end
      ACDT_RUN: begin
        if (pd) begin
          pwr_nxt = ACDT_OFF;
        end
      end
    endcase

    // pipeline advances one entry per input clock edge
    if (sedge && pwr_r != ACDT_OFF) begin
      pipe_nxt[0] = sy2_r[SY_DAT +: SMP_W];
      for (int i = 1; i < PIPE_DLY; i++) begin
        pipe_nxt[i] = pipe_r[i-1];
      end
    end

    // demux phase: a pair every second edge, output clock at half rate
    if (drst) begin
      // a long enough reset puts the pair boundary back on phase 0
      phase_nxt = 1'b0;
      output_data_clock_nxt  = 1'b0;
    end else if (sedge && pwr_r != ACDT_OFF) begin
      phase_nxt = ~phase_r;
      output_data_clock_nxt  = ~output_data_clock_r;
      offer     = phase_r;
    end

    // a pair that finds the buffer full is lost and flagged
    if (offer && !obuf.in_ready) begin
      ovr_nxt = 1'b1;
    end

    // select pin is caught once, on the third cycle after release: the
    // synchroniser leaves reset empty and needs two edges to fill
    if (cal_lat_r == 2'h2) begin
      cal_sel_nxt  = sy2_r[SY_CAL];
      cal_pend_nxt = 1'b1;
    end else if (cal_pend_r && sedge) begin
      if (cal_cnt_r == cal_tgt - 32'h0000_0001) begin
        cal_pend_nxt = 1'b0;
        cal_go_nxt   = 1'b1;
      end else begin
        cal_cnt_nxt = cal_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // registers of the core; low enable freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_DLY; i++) begin
        pipe_r[i] <= '0;
      end
      sclk_d_r   <= 1'b0;
      phase_r    <= 1'b0;
      output_data_clock_r     <= 1'b0;
      ovr_r      <= 1'b0;
      pwr_r      <= ACDT_OFF;
      wake_r     <= '0;
      cal_lat_r  <= 2'h0;
      cal_sel_r  <= 1'b0;
      cal_pend_r <= 1'b0;
      cal_go_r   <= 1'b0;
      cal_cnt_r  <= '0;
    end else if (ce) begin
      pipe_r     <= pipe_nxt;
      sclk_d_r   <= sy2_r[SY_SCLK];
      phase_r    <= phase_nxt;
      output_data_clock_r     <= output_data_clock_nxt;
      ovr_r      <= ovr_nxt;
      pwr_r      <= pwr_nxt;
      wake_r     <= wake_nxt;
      cal_lat_r  <= cal_lat_nxt;
      cal_sel_r  <= cal_sel_nxt;
      cal_pend_r <= cal_pend_nxt;
      cal_go_r   <= cal_go_nxt;
      cal_cnt_r  <= cal_cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// *** sim/acdt_properties.sv ***
// assertion checker on the ports of the converter timing core
`default_nettype none
module acdt_checker
  import acdt_pkg::*;
(
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic         ce,
  input wire logic         power_down_pin,
  input wire logic         output_data_clock_reset,
  input wire logic         out_ready,
  input wire logic         out_valid,
  input wire acdt_sample_t primary_output_bus,
  input wire logic         output_data_clock,
  input wire logic         overrun,
  input wire logic         data_accurate,
  input wire logic         cal_pending,
  input wire logic         cal_start
);
  // ==========================================================
  // cycles since the power-down pin fell; saturates so it never wraps
  // and holds while the enable is low, as the core's timer does
  logic [6:0] low_cnt_r;
  logic [6:0] low_cnt_nxt;
  always_comb low_cnt_nxt = power_down_pin ? 7'h00 :
                            low_cnt_r + {6'h00, low_cnt_r != 7'h7f};
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) low_cnt_r <= 7'h00;
    else if (ce) low_cnt_r <= low_cnt_nxt;
  // ==========================================================
  // frozen clock enable stalls everything, so checks pause with it
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || !ce);
  chk_wake_early: assert property ($rose(data_accurate) |->
    low_cnt_r >= 7'(WAKE_CYC)) else $error("accurate before wake-up");
  chk_wake_late: assert property (low_cnt_r == 7'h40 |->
    data_accurate) else $error("wake-up took too long");
  chk_off_inaccurate: assert property (power_down_pin [*4] |->
    !data_accurate) else $error("accurate while powered down");
  chk_cal_after_wait: assert property ($rose(cal_start) |->
    $past(cal_pending)) else $error("calibration without delay");
  chk_cal_one_pulse: assert property (cal_start |=>
    !cal_start && !cal_pending) else $error("calibration pulse too long");
  chk_pair_held: assert property (out_valid && !out_ready |=>
    out_valid && $stable(primary_output_bus)) else $error("pair lost");
  chk_output_data_clock_quiet: assert property (output_data_clock_reset [*4] |->
    !output_data_clock) else $error("output clock runs in reset");
  chk_overrun_sticky: assert property (overrun |=> overrun)
    else $error("overrun flag cleared");
  cov_cal: cover property (cal_start);
  cov_wake: cover property ($rose(data_accurate));
  cov_full: cover property (overrun);
endmodule
bind acdt_top acdt_checker i_acdt_checker (
  .clk(clk), .arst_n(arst_n), .ce(ce), .power_down_pin(power_down_pin),
  .output_data_clock_reset(output_data_clock_reset), .out_ready(out_ready), .out_valid(out_valid),
  .primary_output_bus(primary_output_bus),
  .output_data_clock(output_data_clock), .overrun(overrun),
  .data_accurate(data_accurate), .cal_pending(cal_pending),
  .cal_start(cal_start));
`default_nettype wire

// *** sim/acdt_rx_model.sv ***
// receiving logic model: drains output pairs, can stall on command
`default_nettype none
module acdt_rx_model
  import acdt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         stall,
  input  wire logic         out_valid,
  input  wire acdt_sample_t primary_output_bus,
  output logic              out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  acdt_sample_t got[$]; // primary samples taken, oldest first
  initial out_ready = 1'b0;
  // take at the edge, then change ready just after it
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready) got.push_back(primary_output_bus);
    out_ready <= !stall;
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench of the converter output timing core
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acdt_pkg::*;
  logic clk, arst_n, ce, sample_clk, pd, cal_sel, output_data_clock_reset, stall;
  logic out_ready, out_valid, out_accurate, output_data_clock_out, pair_ready;
  logic overrun, data_accurate, cal_pending, cal_start;
  acdt_sample_t sample_in, pri_bus, dly_bus, last_val, prev;
  int edge_cnt = 0, fail_count = 0, total_checks = 0, cycles = 0;
  acdt_top #(.CAL_DLY_LO(32'h8), .CAL_DLY_HI(32'h10)) i_acdt_top (
    .clk(clk), .arst_n(arst_n), .ce(ce), .sample_clk(sample_clk),
    .sample_in(sample_in), .power_down_pin(pd),
    .calibration_delay_select(cal_sel), .output_data_clock_reset(output_data_clock_reset),
    .out_ready(out_ready), .out_valid(out_valid),
    .primary_output_bus(pri_bus), .delayed_output_bus(dly_bus),
    .out_accurate(out_accurate), .output_data_clock(output_data_clock_out),
    .pair_ready(pair_ready), .overrun(overrun),
    .data_accurate(data_accurate), .cal_pending(cal_pending),
    .cal_start(cal_start));
  acdt_rx_model i_acdt_rx_model (.clk(clk), .stall(stall),
    .out_valid(out_valid), .primary_output_bus(pri_bus),
    .out_ready(out_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // link clock off the core clock's phase; sample moves on its fall
  initial begin
    sample_clk = 1'b0;
    sample_in = 8'h00;
    #3;
    forever begin
      #80 sample_clk = 1'b1;
      #80 sample_clk = 1'b0;
      sample_in = sample_in + 8'h01;
    end
  end
  always @(posedge sample_clk) begin
    last_val = sample_in;
    edge_cnt++;
  end
  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // release only while the link clock is low, so no false edge is seen
  task automatic t_cal(logic sel, int exp);
    int n = 0;
    @(posedge clk) arst_n <= 1'b0;
    cal_sel <= sel;
    repeat (10) @(posedge clk);
    @(negedge sample_clk);
    @(posedge clk) arst_n <= 1'b1;
    edge_cnt = 0;
    repeat (6) @(negedge clk);
    check("cal_pending", 1, cal_pending);
    while (cal_start !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check("cal edges", exp, edge_cnt);
  endtask
  task automatic t_stream(int pairs);
    acdt_sample_t e;
    while (edge_cnt < 16) @(negedge clk);
    for (int i = 0; i < pairs; i++) begin
      for (int n = 0; n < 100 && !(out_valid === 1'b1 && out_ready); n++)
        @(negedge clk);
      e = last_val - 8'(PIPE_PRI);
      check("primary", e, pri_bus);
      e = last_val - 8'(PIPE_DLY);
      check("delayed", e, dly_bus);
      e = prev + 8'h02;
      if (i > 0) check("step", e, pri_bus);
      check("out_accurate", 1, out_accurate);
      prev = pri_bus;
      @(negedge clk);
    end
  endtask
  task automatic t_output_data_clock();
    @(posedge clk) output_data_clock_reset <= 1'b1; // well past four cycles
    repeat (8) @(negedge clk);
    check("output_data_clock held", 0, output_data_clock_out);
    @(posedge clk) output_data_clock_reset <= 1'b0;
    t_stream(3);
  endtask
  task automatic t_stall();
    acdt_sample_t e;
    @(posedge clk) stall <= 1'b1;
    repeat (140) @(negedge clk);
    check("pair_ready", 0, pair_ready);
    check("overrun", 1, overrun);
    i_acdt_rx_model.got.delete();
    @(posedge clk) stall <= 1'b0;
    repeat (4) @(negedge clk);
    check("drained", 1, i_acdt_rx_model.got.size() >= 2);
    e = i_acdt_rx_model.got[0] + 8'h02;
    check("drain step", e, i_acdt_rx_model.got[1]);
  endtask
  task automatic t_power();
    int n = 0;
    @(posedge clk) pd <= 1'b1;
    repeat (40) @(negedge clk);
    check("accurate off", 0, data_accurate);
    // wake with the enable low for 20 cycles: the timer must not run
    @(posedge clk) pd <= 1'b0;
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    while (data_accurate !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("wake", 1, n >= WAKE_CYC && n <= WAKE_CYC + 6);
  endtask
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    pd = 1'b0;
    cal_sel = 1'b0;
    output_data_clock_reset = 1'b0;
    stall = 1'b0;
    t_cal(1'b1, 16);
    t_cal(1'b0, 8);
    t_stream(6);
    t_output_data_clock();
    t_stall();
    t_power();
    summarize();
  end
endmodule
`default_nettype wire
